//--- disk_ctrl_defines.svh
// Offsets, field positions, reset values and timing counts of the drive control block
`ifndef DISK_CTRL_DEFINES_SVH
`define DISK_CTRL_DEFINES_SVH

// Register byte offsets
`define OFF_DATA 12'h000
`define OFF_PRECOMP 12'h004
`define OFF_SECCOUNT 12'h008
`define OFF_SECNUM 12'h00c
`define OFF_CYLLOW 12'h010
`define OFF_CYLHIGH 12'h014
`define OFF_SIZEDRVHEAD 12'h018
`define OFF_CMDSTAT 12'h01c
`define OFF_ERROR 12'h020

// Reset values
`define RST_STEPRATE 4'hf
`define RST_PRECOMP 8'h80
`define RST_SECCOUNT 8'h01

// Command opcodes, upper nibble, and the DMA bit position
`define CMD_RESTORE 4'h1
`define CMD_SEEK 4'h7
`define CMD_READ 4'h2
`define CMD_WRITE 4'h3
`define CMD_FORMAT 4'h5
`define CMD_DMA_BIT 3

// Size/drive/head fields
`define SDH_DRV_LSB 3
`define SDH_HEAD_LSB 0

// Status bit positions
`define ST_BUSY 7
`define ST_READY 6
`define ST_WFAULT 5
`define ST_SEEKDONE 4
`define ST_DATAREQ 3
`define ST_ERROR 0

// Error bit positions
`define ER_TIMEOUT 4
`define ER_ABORT 2
`define ER_TRKZERO 1

// Timing: clock rate and times in their own units
`define CLK_MHZ 250
`define STEP_UNIT_US 500
`define STEP_MIN_US 10
`define STEP_PULSE_NS 1000
`define STEP_UNIT_CYCLES (`STEP_UNIT_US * `CLK_MHZ)
`define STEP_MIN_CYCLES (`STEP_MIN_US * `CLK_MHZ)
`define STEP_PULSE_CYCLES ((`STEP_PULSE_NS * `CLK_MHZ + 999) / 1000)

// Step limit for a restore and revolutions allowed before a retry gives up
`define RESTORE_MAX_STEPS 10'h3ff
`define RETRY_REVS 2

`endif

//--- disk_ctrl_pkg.sv
// Types shared by the drive control block
package disk_ctrl_pkg;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0000,
      S_STEP_CHECK = 4'b0001,
      S_STEP_HIGH = 4'b0010,
      S_STEP_GAP = 4'b0011,
      S_AUTO_WAIT = 4'b0100,
      S_SETTLE = 4'b0101,
      S_HOST_FILL = 4'b0110,
      S_INDEX_WAIT = 4'b0111,
      S_RECORD = 4'b1000,
      S_HOST_DRAIN = 4'b1001
   } state_e;

   // Outputs toward the daisy-chained drives
   typedef struct packed {
      logic [3:0] driveSelect;
      logic [2:0] headSelect;
      logic step;
      logic direction;
      logic writeGate;
      logic reduceWriteCurrent;
   } drive_ctl_s;

   // Inputs from the selected drive
   typedef struct packed {
      logic seekComplete;
      logic trackZeroInput;
      logic writeFault;
      logic index;
      logic ready;
   } drive_stat_s;

endpackage

//--- disk_drive_control_interface.sv
// Drive control sequencer with host data request, reset defaults and APB task file
`timescale 1ns/1ps
`include "disk_ctrl_defines.svh"

//
// Contract
// - Data request is high while the buffer waits for host reads or writes.
// - Any data register access drops the data request.
// - Data request returns after each access until buffer done or cylinder-low access.
// - Master reset clears sector, cylinder, size/drive/head; step rate becomes 7.5 ms.
// - Master reset sets precompensation to 128 (cylinder 512) and sector count to 1.
// - Master reset drops data request and raises the completion interrupt.
// - Reduce write current with write gate when cylinder >= four times precomp.
// - Reduce write current only matters during write or format commands.
// - Write gate is high only while data is being recorded.
// - An explicit seek finishes after its steps without waiting for seek complete.
// - Track zero is sampled just before each restore step pulse and each outward implied-seek step pulse.
// - No command runs while the drive reports a write fault.
// - Three head select outputs pick the head on the selected drive.
// - Index pulses synchronise formatting and time out retries.
// - No command runs unless the drive reports ready.
// - One step pulse per cylinder, sense given by the direction output.
// - Step spacing: stored rate for implied seeks, command rate for seek/restore.
// - Automatic restore paces each step by the drive's seek complete.
// - Direction high steps outward, low steps inward.
// - Status read or new command clears the completion interrupt.
// - Four drive select outputs, none asserted after reset and one once a command latches them, choose one of four drives.
module disk_drive_control_interface #(
   parameter int SECTOR_BYTES = 256,
   parameter int STEP_UNIT_CYCLES = `STEP_UNIT_CYCLES,
   parameter int STEP_MIN_CYCLES = `STEP_MIN_CYCLES,
   parameter int WRITE_CYCLES = SECTOR_BYTES * 8
) (
   // Clock and resets
   input wire logic clock,
   input wire logic rst,
   input wire logic boardMasterReset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Host side lines
   output logic bufferDataRequest,
   output logic commandDoneInterrupt,
   // Drive control cable
   output disk_ctrl_pkg::drive_ctl_s driveCtl,
   input wire disk_ctrl_pkg::drive_stat_s driveStat
);

   localparam int PW = $clog2(SECTOR_BYTES) + 1;
   localparam logic [PW-1:0] LAST = PW'(SECTOR_BYTES - 1);

   disk_ctrl_pkg::state_e state;
   logic resetAll;
   logic [7:0] buffer [0:SECTOR_BYTES-1];
   logic [PW-1:0] bytePtr;
   logic [7:0] precompReg, secCountReg, secNumReg, cylLowReg, cylHighReg, sizeDriveHeadReg;
   logic [7:0] commandReg, errorReg;
   logic [3:0] stepRateReg, activeRate;
   logic [9:0] headPos [0:3];
   logic [9:0] targetCyl, stepsLeft, stepCount;
   logic [1:0] driveNum;
   logic restoreMode, autoRestore, explicitSeek, busy, errFlag, bufPending;
   logic [31:0] timer;
   logic [1:0] indexCount;
   logic indexPrev, indexRise;
   logic acc, wrAcc, rdAcc, dataAcc, cylLowAcc, cmdWrite, statusRead;
   logic setIrq, startOk, finish;
   logic [7:0] statusByte;
   logic mapped;
   logic [31:0] gapCycles;

   assign resetAll = rst | boardMasterReset;

   // Access phase of an APB transfer; the slave never inserts wait states
   assign acc = psel & penable;
   assign pready = acc;
   assign wrAcc = acc & pwrite;
   assign rdAcc = acc & ~pwrite;
   assign dataAcc = acc & (paddr == `OFF_DATA);
   assign cylLowAcc = acc & (paddr == `OFF_CYLLOW);
   assign cmdWrite = wrAcc & (paddr == `OFF_CMDSTAT);
   assign statusRead = rdAcc & (paddr == `OFF_CMDSTAT);
   assign indexRise = driveStat.index & ~indexPrev;
   assign targetCyl = {cylHighReg[1:0], cylLowReg};
   assign driveNum = sizeDriveHeadReg[`SDH_DRV_LSB +: 2];
   assign startOk = driveStat.ready & ~driveStat.writeFault & driveStat.seekComplete;

   // Unmapped offsets answer with an error and read zero
   always_comb begin
      mapped = 1'b0;
      case (paddr)
         `OFF_DATA, `OFF_PRECOMP, `OFF_SECCOUNT, `OFF_SECNUM, `OFF_CYLLOW,
         `OFF_CYLHIGH, `OFF_SIZEDRVHEAD, `OFF_CMDSTAT, `OFF_ERROR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = acc & ~mapped;

   // Gap between steps from the 4-bit rate code; code zero is the short rate
   assign gapCycles = (activeRate == 4'h0) ? STEP_MIN_CYCLES :
                      ({28'h0000000, activeRate} * 32'(STEP_UNIT_CYCLES));

   always_comb begin
      statusByte = 8'h00;
      statusByte[`ST_BUSY] = busy;
      statusByte[`ST_READY] = driveStat.ready;
      statusByte[`ST_WFAULT] = driveStat.writeFault;
      statusByte[`ST_SEEKDONE] = driveStat.seekComplete;
      statusByte[`ST_DATAREQ] = bufferDataRequest;
      statusByte[`ST_ERROR] = errFlag;
   end

   // Read data is captured in the setup cycle so the access cycle sees a flop
   always_ff @(posedge clock) begin
      if (resetAll) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `OFF_DATA: prdata <= {24'h000000, buffer[bytePtr[PW-2:0]]};
            `OFF_PRECOMP: prdata <= {24'h000000, precompReg};
            `OFF_SECCOUNT: prdata <= {24'h000000, secCountReg};
            `OFF_SECNUM: prdata <= {24'h000000, secNumReg};
            `OFF_CYLLOW: prdata <= {24'h000000, cylLowReg};
            `OFF_CYLHIGH: prdata <= {24'h000000, cylHighReg};
            `OFF_SIZEDRVHEAD: prdata <= {24'h000000, sizeDriveHeadReg};
            `OFF_CMDSTAT: prdata <= {24'h000000, statusByte};
            `OFF_ERROR: prdata <= {24'h000000, errorReg};
            default: prdata <= 32'h00000000;
         endcase
      end
   end

   // Task file registers; writes while busy are ignored to keep the command stable
   always_ff @(posedge clock) begin
      if (resetAll) begin
         precompReg <= `RST_PRECOMP;
         secCountReg <= `RST_SECCOUNT;
         secNumReg <= 8'h00;
         cylLowReg <= 8'h00;
         cylHighReg <= 8'h00;
         sizeDriveHeadReg <= 8'h00;
      end else if (cmdWrite & ~busy & (pwdata[7:4] == `CMD_RESTORE)) begin
         cylLowReg <= 8'h00;
         cylHighReg <= 8'h00;
      end else if (wrAcc & ~busy) begin
         case (paddr)
            `OFF_PRECOMP: precompReg <= pwdata[7:0];
            `OFF_SECCOUNT: secCountReg <= pwdata[7:0];
            `OFF_SECNUM: secNumReg <= pwdata[7:0];
            `OFF_CYLLOW: cylLowReg <= pwdata[7:0];
            `OFF_CYLHIGH: cylHighReg <= pwdata[7:0];
            `OFF_SIZEDRVHEAD: sizeDriveHeadReg <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Sector buffer storage; host writes land at the transfer pointer
   always_ff @(posedge clock) begin
      if (dataAcc & pwrite) begin
         buffer[bytePtr[PW-2:0]] <= pwdata[7:0];
      end
   end

   // Completion interrupt: a set in the clearing cycle wins
   always_ff @(posedge clock) begin
      if (resetAll) begin
         commandDoneInterrupt <= 1'b1;
      end else if (setIrq) begin
         commandDoneInterrupt <= 1'b1;
      end else if (statusRead | (cmdWrite & ~busy)) begin
         commandDoneInterrupt <= 1'b0;
      end
   end

   // Data request drops for the access cycle and returns while bytes remain
   always_ff @(posedge clock) begin
      if (resetAll) begin
         bufferDataRequest <= 1'b0;
      end else if (dataAcc | cylLowAcc) begin
         bufferDataRequest <= 1'b0;
      end else begin
         bufferDataRequest <= bufPending;
      end
   end

   // Index edge detection; inputs are already synchronous to the clock
   always_ff @(posedge clock) begin
      if (resetAll) begin
         indexPrev <= 1'b0;
      end else begin
         indexPrev <= driveStat.index;
      end
   end

   // Write current reduction is only driven with the gate during write/format
   always_comb begin
      driveCtl.reduceWriteCurrent = driveCtl.writeGate &
         ({1'b0, targetCyl} >= {1'b0, precompReg, 2'b00});
   end

   // Command sequencer
   always_ff @(posedge clock) begin
      if (resetAll) begin
         state <= disk_ctrl_pkg::S_IDLE;
         stepRateReg <= `RST_STEPRATE;
         activeRate <= `RST_STEPRATE;
         commandReg <= 8'h00;
         errorReg <= 8'h00;
         errFlag <= 1'b0;
         busy <= 1'b0;
         bufPending <= 1'b0;
         bytePtr <= '0;
         stepsLeft <= 10'h000;
         stepCount <= 10'h000;
         restoreMode <= 1'b0;
         autoRestore <= 1'b0;
         explicitSeek <= 1'b0;
         timer <= 32'h00000000;
         indexCount <= 2'b00;
         setIrq <= 1'b0;
         finish <= 1'b0;
         headPos <= '{default: 10'h000};
         driveCtl.driveSelect <= 4'h0;
         driveCtl.headSelect <= 3'h0;
         driveCtl.step <= 1'b0;
         driveCtl.direction <= 1'b0;
         driveCtl.writeGate <= 1'b0;
      end else begin
         setIrq <= 1'b0;
         // Host data transfers advance the pointer only while the buffer is pending
         if (bufPending & dataAcc) begin
            bytePtr <= bytePtr + PW'(1);
         end
         if (bufPending & cylLowAcc) begin
            bufPending <= 1'b0;
         end
         case (state)
            disk_ctrl_pkg::S_IDLE: begin
               if (cmdWrite) begin
                  commandReg <= pwdata[7:0];
                  busy <= 1'b1;
                  errorReg <= 8'h00;
                  errFlag <= 1'b0;
                  // Selects latch once per command so they cannot change mid-move
                  driveCtl.driveSelect <= 4'h1 << driveNum;
                  driveCtl.headSelect <= sizeDriveHeadReg[`SDH_HEAD_LSB +: 3];
                  restoreMode <= 1'b0;
                  autoRestore <= 1'b0;
                  stepCount <= 10'h000;
                  explicitSeek <= (pwdata[7:4] == `CMD_SEEK);
                  if (!startOk) begin
                     errorReg[`ER_ABORT] <= 1'b1;
                     errFlag <= 1'b1;
                     busy <= 1'b0;
                     setIrq <= 1'b1;
                  end else if (pwdata[7:4] == `CMD_RESTORE) begin
                     stepRateReg <= pwdata[3:0];
                     activeRate <= pwdata[3:0];
                     restoreMode <= 1'b1;
                     headPos[driveNum] <= 10'h000;
                     driveCtl.direction <= 1'b1;
                     state <= disk_ctrl_pkg::S_STEP_CHECK;
                  end else begin
                     if (pwdata[7:4] == `CMD_SEEK) begin
                        stepRateReg <= pwdata[3:0];
                        activeRate <= pwdata[3:0];
                     end else begin
                        activeRate <= stepRateReg;
                     end
                     headPos[driveNum] <= targetCyl;
                     driveCtl.direction <= (targetCyl < headPos[driveNum]);
                     stepsLeft <= (targetCyl < headPos[driveNum]) ?
                        (headPos[driveNum] - targetCyl) : (targetCyl - headPos[driveNum]);
                     state <= disk_ctrl_pkg::S_STEP_CHECK;
                  end
               end
            end
            disk_ctrl_pkg::S_STEP_CHECK: begin
               // Track zero is looked at here, right before a restore or outward implied-seek pulse goes out
               if (restoreMode) begin
                  if (driveStat.trackZeroInput) begin
                     restoreMode <= 1'b0;
                     if (autoRestore) begin
                        // Re-seek inward from cylinder zero at the stored rate
                        autoRestore <= 1'b0;
                        driveCtl.direction <= 1'b0;
                        stepsLeft <= targetCyl;
                     end else begin
                        finish <= 1'b1;
                        state <= disk_ctrl_pkg::S_IDLE;
                     end
                  end else if (stepCount == `RESTORE_MAX_STEPS) begin
                     errorReg[`ER_TRKZERO] <= 1'b1;
                     errFlag <= 1'b1;
                     finish <= 1'b1;
                     state <= disk_ctrl_pkg::S_IDLE;
                  end else begin
                     stepCount <= stepCount + 10'h001;
                     timer <= 32'(`STEP_PULSE_CYCLES);
                     driveCtl.step <= 1'b1;
                     state <= disk_ctrl_pkg::S_STEP_HIGH;
                  end
               end else if (stepsLeft == 10'h000) begin
                  if (explicitSeek) begin
                     finish <= 1'b1;
                     state <= disk_ctrl_pkg::S_IDLE;
                  end else begin
                     indexCount <= 2'b00;
                     state <= disk_ctrl_pkg::S_SETTLE;
                  end
               end else if (driveCtl.direction & driveStat.trackZeroInput & ~explicitSeek) begin
                  // Head already at zero yet steps remain outward: position lost
                  autoRestore <= 1'b1;
                  restoreMode <= 1'b1;
                  stepCount <= 10'h000;
               end else begin
                  stepsLeft <= stepsLeft - 10'h001;
                  timer <= 32'(`STEP_PULSE_CYCLES);
                  driveCtl.step <= 1'b1;
                  state <= disk_ctrl_pkg::S_STEP_HIGH;
               end
            end
            disk_ctrl_pkg::S_STEP_HIGH: begin
               if (timer <= 32'h00000001) begin
                  driveCtl.step <= 1'b0;
                  timer <= gapCycles;
                  state <= autoRestore ? disk_ctrl_pkg::S_AUTO_WAIT :
                                         disk_ctrl_pkg::S_STEP_GAP;
               end else begin
                  timer <= timer - 32'h00000001;
               end
            end
            disk_ctrl_pkg::S_STEP_GAP: begin
               if (timer <= 32'h00000001) begin
                  state <= disk_ctrl_pkg::S_STEP_CHECK;
               end else begin
                  timer <= timer - 32'h00000001;
               end
            end
            disk_ctrl_pkg::S_AUTO_WAIT: begin
               // Drive's own settle time paces the recovery steps
               if (driveStat.seekComplete) begin
                  state <= disk_ctrl_pkg::S_STEP_CHECK;
               end
            end
            disk_ctrl_pkg::S_SETTLE: begin
               if (driveStat.seekComplete) begin
                  bytePtr <= '0;
                  bufPending <= 1'b1;
                  if (commandReg[7:4] == `CMD_READ) begin
                     setIrq <= ~commandReg[`CMD_DMA_BIT];
                     state <= disk_ctrl_pkg::S_HOST_DRAIN;
                  end else begin
                     state <= disk_ctrl_pkg::S_HOST_FILL;
                  end
               end else if (indexRise) begin
                  // Index gives the retry timeout in whole revolutions
                  if (indexCount == 2'(`RETRY_REVS - 1)) begin
                     errorReg[`ER_TIMEOUT] <= 1'b1;
                     errFlag <= 1'b1;
                     finish <= 1'b1;
                     state <= disk_ctrl_pkg::S_IDLE;
                  end else begin
                     indexCount <= indexCount + 2'b01;
                  end
               end
            end
            disk_ctrl_pkg::S_HOST_FILL: begin
               if (~bufPending) begin
                  finish <= 1'b1;
                  state <= disk_ctrl_pkg::S_IDLE;
               end else if (dataAcc & (bytePtr == LAST)) begin
                  bufPending <= 1'b0;
                  timer <= 32'(WRITE_CYCLES);
                  if (commandReg[7:4] == `CMD_FORMAT) begin
                     state <= disk_ctrl_pkg::S_INDEX_WAIT;
                  end else begin
                     driveCtl.writeGate <= 1'b1;
                     state <= disk_ctrl_pkg::S_RECORD;
                  end
               end
            end
            disk_ctrl_pkg::S_INDEX_WAIT: begin
               if (indexRise) begin
                  driveCtl.writeGate <= 1'b1;
                  state <= disk_ctrl_pkg::S_RECORD;
               end
            end
            disk_ctrl_pkg::S_RECORD: begin
               // Format records one full revolution; a sector a fixed time
               if ((commandReg[7:4] == `CMD_FORMAT) ? indexRise :
                   (timer <= 32'h00000001)) begin
                  driveCtl.writeGate <= 1'b0;
                  finish <= 1'b1;
                  state <= disk_ctrl_pkg::S_IDLE;
               end else begin
                  timer <= timer - 32'h00000001;
               end
            end
            disk_ctrl_pkg::S_HOST_DRAIN: begin
               if (~bufPending | (dataAcc & (bytePtr == LAST))) begin
                  bufPending <= 1'b0;
                  finish <= 1'b1;
                  state <= disk_ctrl_pkg::S_IDLE;
               end
            end
            default: state <= disk_ctrl_pkg::S_IDLE;
         endcase
         // Completion: drop busy and raise the interrupt unless a non-DMA read raised it
         if (finish) begin
            finish <= 1'b0;
            busy <= 1'b0;
            if (!((commandReg[7:4] == `CMD_READ) & ~commandReg[`CMD_DMA_BIT] & ~errFlag)) begin
               setIrq <= 1'b1;
            end
         end
      end
   end

endmodule

//--- disk_drive_control_interface_props.sv
// Port checks for the drive control block
`timescale 1ns/1ps
module disk_drive_control_interface_props (
   // Clock and resets
   input wire logic clock,
   input wire logic rst,
   input wire logic boardMasterReset,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Host lines and cable
   input wire logic bufferDataRequest,
   input wire logic commandDoneInterrupt,
   input wire disk_ctrl_pkg::drive_ctl_s driveCtl,
   input wire disk_ctrl_pkg::drive_stat_s driveStat
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst || boardMasterReset);
   // Access phase, and a command write within it
   sequence s_acc;
      psel && penable;
   endsequence
   sequence s_cmd;
      s_acc ##0 (pwrite && paddr == 12'h01c);
   endsequence
   a_reset_state: assert property (disable iff (1'b0) rst |=> commandDoneInterrupt &&
      !bufferDataRequest && driveCtl.driveSelect == 4'h0) else $error("reset state wrong");
   a_data_drop: assert property (s_acc ##0 paddr == 12'h000 |=> !bufferDataRequest)
      else $error("data request kept after data access");
   a_rwc_gate: assert property (driveCtl.reduceWriteCurrent |-> driveCtl.writeGate)
      else $error("reduced current without write gate");
   a_one_drive: assert property ($onehot0(driveCtl.driveSelect))
      else $error("more than one drive selected");
   a_step_hold: assert property (driveCtl.step && $past(driveCtl.step) |->
      $stable({driveCtl.driveSelect, driveCtl.headSelect, driveCtl.direction}))
      else $error("select or direction moved during step");
   a_step_width: assert property ($rose(driveCtl.step) |=> driveCtl.step [*8])
      else $error("step pulse too short");
   a_fault_abort: assert property (s_cmd ##0 (driveStat.writeFault || !driveStat.ready)
      |-> ##[1:3] commandDoneInterrupt) else $error("refused command gave no interrupt");
   a_status_clear: assert property (s_acc ##0 (!pwrite && paddr == 12'h01c && !prdata[7])
      |=> !commandDoneInterrupt) else $error("status read left interrupt set");
   a_unmapped_err: assert property (s_acc ##0 paddr > 12'h020 |-> pslverr)
      else $error("unmapped access without error");
endmodule

bind disk_drive_control_interface disk_drive_control_interface_props chk (.clock, .rst,
   .boardMasterReset, .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
   .bufferDataRequest, .commandDoneInterrupt, .driveCtl, .driveStat);

//--- disk_drive_model.sv
// Behavioural drive on the control cable: head position, settle time and index
`timescale 1ns/1ps
module disk_drive_model #(
   parameter int INIT_CYL = 3,
   parameter int REV = 600
) (
   // Clock and cable
   input wire logic clock,
   input wire disk_ctrl_pkg::drive_ctl_s ctl,
   output disk_ctrl_pkg::drive_stat_s stat,
   // Bench controls
   input wire logic faultIn,
   input wire logic notReady,
   input wire logic slow,
   output int headPos
);
   logic stepPrev = 1'b0;
   int settle = 0;
   int rev = 0;
   initial headPos = INIT_CYL;
   // Slow mode settles long after an explicit seek has ended
   always @(posedge clock) begin
      stepPrev <= ctl.step;
      rev <= (rev == REV - 1) ? 0 : rev + 1;
      if (ctl.step && !stepPrev) begin
         headPos <= ctl.direction ? (headPos > 0 ? headPos - 1 : 0) : headPos + 1;
         settle <= slow ? 2000 : 30;
      end else if (settle > 0) begin
         settle <= settle - 1;
      end
   end
   // Status lines toward the controller
   assign stat.seekComplete = settle == 0 && !ctl.step;
   assign stat.trackZeroInput = headPos == 0;
   assign stat.index = rev < 4;
   assign stat.writeFault = faultIn;
   assign stat.ready = !notReady;
endmodule

//--- tb_disk_drive_control_interface.sv
// Self-checking bench for the drive control block
`timescale 1ns/1ps
module tb_disk_drive_control_interface;
   logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, faultIn = 0, notReady = 0;
   logic slow = 0, stepPrev = 0, lastDir, apbErr, pready, pslverr;
   logic bufferDataRequest, commandDoneInterrupt;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hc677;
   logic [11:0] offs[6] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018};
   logic [31:0] rv[6] = '{32'h80, 32'h01, 32'h00, 32'h00, 32'h00, 32'h00};
   disk_ctrl_pkg::drive_ctl_s driveCtl;
   disk_ctrl_pkg::drive_stat_s driveStat;
   int errCount = 0, checked = 0, cycles = 0, stepCount = 0, lastRise = 0, period = 0;
   int headPos, r, t, d, h;
   disk_drive_control_interface #(.SECTOR_BYTES(4), .STEP_UNIT_CYCLES(20),
      .STEP_MIN_CYCLES(5), .WRITE_CYCLES(16)) dut (.clock, .rst, .boardMasterReset(1'b0),
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .bufferDataRequest, .commandDoneInterrupt, .driveCtl, .driveStat);
   disk_drive_model drive (.clock, .ctl(driveCtl), .stat(driveStat), .faultIn, .notReady,
      .slow, .headPos);
   always #2 clock = ~clock;
   // Step monitor and watchdog, sampled mid-cycle to stay clear of edge races
   always @(negedge clock) begin
      cycles++;
      stepPrev <= driveCtl.step;
      if (driveCtl.step && !stepPrev) begin
         stepCount++;
         period = cycles - lastRise;
         lastRise = cycles;
         lastDir = driveCtl.direction;
      end
      if (cycles > 30000) begin
         errCount++;
         conclude();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h got %h", n, e, g);
         errCount++;
      end
   endtask
   // One APB transfer; ends one edge after release so calls never collide
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge clock);
      penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      apbErr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clock);
   endtask
   task automatic waitInt();
      do @(posedge clock); while (commandDoneInterrupt !== 1'b1);
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", checked, errCount);
      if (errCount == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      chk("intr", 1, commandDoneInterrupt);
      chk("drq", 0, bufferDataRequest);
      foreach (offs[i]) begin
         apb(0, offs[i], 0);
         chk("regReset", rv[i], rd);
      end
      apb(0, 12'h100, 0);
      chk("unmapped", 1, apbErr);
      // Fault then not-ready: each command must be turned away
      for (int i = 0; i < 2; i++) begin
         faultIn <= i == 0;
         notReady <= i == 1;
         apb(1, 12'h01c, 8'h11);
         @(posedge clock);
         chk("abortInt", 1, commandDoneInterrupt);
         apb(0, 12'h01c, 0);
         chk("abortErr", 1, rd[0]);
         chk("intClear", 0, commandDoneInterrupt);
      end
      chk("noStep", 0, stepCount);
      faultIn <= 0;
      notReady <= 0;
      r = rnd() % 3 + 1;
      apb(1, 12'h01c, 8'h10 | 8'(r));
      waitInt();
      chk("restoreSteps", 3, stepCount);
      chk("restoreDir", 1, lastDir);
      chk("restorePos", 0, headPos);
      chk("restoreGap", 1, period >= 250 + r * 20 && period <= 252 + r * 20);
      // Explicit seek must end while the drive is still settling
      t = rnd() % 6 + 2;
      stepCount = 0;
      slow <= 1;
      apb(1, 12'h010, 8'(t));
      apb(1, 12'h01c, 8'h70);
      waitInt();
      chk("seekSteps", t, stepCount);
      chk("seekDir", 0, lastDir);
      chk("seekPos", t, headPos);
      chk("seekNoWait", 0, driveStat.seekComplete);
      chk("seekGap", 1, period >= 255 && period <= 257);
      slow <= 0;
      do @(posedge clock); while (driveStat.seekComplete !== 1'b1);
      // Write sector above and below the reduced-current threshold
      for (int k = 1; k < 3; k++) begin
         d = rnd() % 4;
         h = rnd() % 8;
         apb(1, 12'h004, 8'(k));
         apb(1, 12'h010, 8'h05);
         apb(1, 12'h018, 8'((d << 3) | h));
         apb(1, 12'h01c, 8'h30);
         repeat (4) begin
            do @(posedge clock); while (bufferDataRequest !== 1'b1);
            apb(1, 12'h000, 8'(rnd()));
         end
         do @(posedge clock); while (driveCtl.writeGate !== 1'b1);
         chk("rwc", 5 >= 4 * k, driveCtl.reduceWriteCurrent);
         chk("driveSel", 1 << d, driveCtl.driveSelect);
         chk("headSel", h, driveCtl.headSelect);
         waitInt();
         chk("gateOff", 0, driveCtl.writeGate);
      end
      conclude();
   end
endmodule
